// ### hw/display_dram_strobe_config.sv
// Display DRAM configuration registers and CAS/WE strobe mapping
// Overview of operation
// RULE_01 - Display memory totals 1, 2 or 4MB
// RULE_02 - FPM/EDO parts 128K-512K deep, x8-x32
// RULE_03 - Data path 64 bits, or 32 bits
// RULE_04 - Panel buffer is one 256Kx16 DRAM
// RULE_05 - Buffer takes upper half, bank two
// RULE_06 - Software sets option bits 7 and 0
// RULE_07 - Type bits 1:0 choose FPM or EDO
// RULE_08 - Option bit 2 sets buffer DRAM type
// RULE_09 - Main and buffer configured independently
// RULE_10 - Config bit 4 selects dual-WE main
// RULE_11 - Option bit 6 selects dual-WE buffer
// RULE_12 - Wide dual-WE remaps groups A to D
// RULE_13 - Narrow dual-WE remaps only groups A, B
// RULE_14 - Buffer uses group C strobes, remapped
// RULE_15 - Dual-WE: common CAS, per-byte WE writes
`timescale 1ns/1ps
`default_nettype none
module display_dram_strobe_config
  import dram_strobe_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Main memory access request, group enable per group
  input wire logic [NUM_GRP-1:0] main_cas_n,
  input wire logic main_we_n,
  input wire logic [2*NUM_GRP-1:0] main_byte_en,
  // Panel buffer access request
  input wire logic buf_cas_n,
  input wire logic buf_we_n,
  input wire logic [1:0] buf_byte_en,
  // Strobe pins, active low, registered
  output logic [NUM_GRP-1:0] col_strobe_hi_n,
  output logic [NUM_GRP-1:0] col_strobe_lo_n,
  output logic [NUM_GRP-1:0] write_strobe_n,
  // Decoded configuration for the cycle engine
  output logic main_edo,
  output logic buf_edo,
  output logic buf_active,
  output logic wide_path
);

  typedef struct packed {
    bus_state_t st;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] dram_type_reg;
    logic [7:0] dram_config_reg;
    logic [7:0] panel_mem_option_reg;
    logic [NUM_GRP-1:0] cas_hi;
    logic [NUM_GRP-1:0] cas_lo;
    logic [NUM_GRP-1:0] we;
  } state_t;

  state_t q, d;

  // Byte-lane merge of a write into the low byte
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] sel);
    merge = sel[0] ? wd[7:0] : old;
  endfunction

  // Pin triple for one byte pair: {cas_hi, cas_lo, we}, active low
  function automatic logic [2:0] pins(input logic dual_we,
                                      input logic cas_n,
                                      input logic we_n,
                                      input logic [1:0] be);
    logic wr;
    wr = ~we_n & ~cas_n;
    if (dual_we) begin
      // Common CAS, low-byte WE, high-byte WE
      pins = {cas_n, ~(wr & be[0]), ~(wr & be[1])}; // RULE_15
    end else begin
      pins = {~(~cas_n & be[1]), ~(~cas_n & be[0]), we_n};
    end
  endfunction

  logic sel_hit;
  logic buf_en;
  logic wide;
  logic main_dwe;
  logic buf_dwe;
  logic [1:0] size_cfg;
  logic [31:0] status;

  always_comb begin
    // Buffer needs both enable bits set by software
    buf_en = q.panel_mem_option_reg[PMO_BUF_EN7]
           & q.panel_mem_option_reg[PMO_BUF_EN0]; // RULE_06
    // Buffer forces a 32-bit single-bank main path
    wide = q.dram_config_reg[CFG_WIDE] & ~buf_en; // RULE_05 RULE_03
    main_dwe = q.dram_config_reg[CFG_DUAL_WE]; // RULE_10
    buf_dwe = q.panel_mem_option_reg[PMO_BUF_DUAL_WE]; // RULE_11 RULE_09
    size_cfg = q.dram_config_reg[CFG_SIZE_LO +: 2]; // RULE_01
    status = {27'h0, buf_en, wide, q.dram_type_reg[TYPE_LO +: 2] == TYPE_EDO,
              size_cfg};
  end

  assign sel_hit = wb_cyc_i & wb_stb_i;

  always_comb begin
    logic [2:0] p;
    p = 3'h7;
    d = q;
    d.ack = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (sel_hit) begin
          d.st = ST_ACK;
          d.ack = 1'b1;
          if (wb_we_i) begin
            case (wb_adr_i)
              ADDR_DRAM_TYPE: begin
                d.dram_type_reg = merge(q.dram_type_reg, wb_dat_i,
                                        wb_sel_i); // RULE_07
              end
              ADDR_DRAM_CONFIG: begin
                d.dram_config_reg = merge(q.dram_config_reg, wb_dat_i,
                                          wb_sel_i);
                // Unsupported size code falls back to 4MB
                if (d.dram_config_reg[CFG_SIZE_LO +: 2] == 2'h3) begin
                  d.dram_config_reg[CFG_SIZE_LO +: 2] = SIZE_4MB; // RULE_01
                end
              end
              ADDR_PANEL_MEM_OPTION: begin
                d.panel_mem_option_reg = merge(q.panel_mem_option_reg,
                                               wb_dat_i, wb_sel_i);
              end
              default: begin
              end
            endcase
          end else begin
            case (wb_adr_i)
              ADDR_DRAM_TYPE: d.rdata = {24'h0, q.dram_type_reg};
              ADDR_DRAM_CONFIG: d.rdata = {24'h0, q.dram_config_reg};
              ADDR_PANEL_MEM_OPTION: begin
                d.rdata = {24'h0, q.panel_mem_option_reg};
              end
              ADDR_STATUS: d.rdata = status;
              default: d.rdata = 32'h0;
            endcase
          end
        end
      end
      ST_ACK: begin
        d.st = ST_IDLE;
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // Strobe mapping per group
    for (int g = 0; g < NUM_GRP; g++) begin
      if (g == GRP_C && buf_en) begin
        // Panel buffer driven through group C
        p = pins(buf_dwe, buf_cas_n, buf_we_n, buf_byte_en); // RULE_14 RULE_04
      end else if (!wide && g >= 2) begin
        // Upper half idle on narrow path
        p = 3'h7; // RULE_13
      end else begin
        p = pins(main_dwe, main_cas_n[g], main_we_n,
                 main_byte_en[2*g +: 2]); // RULE_12 RULE_02
      end
      d.cas_hi[g] = p[2];
      d.cas_lo[g] = p[1];
      d.we[g] = p[0];
    end

    if (rst) begin
      d = '0;
      d.st = ST_IDLE;
      d.dram_type_reg = DRAM_TYPE_RST;
      d.dram_config_reg = DRAM_CONFIG_RST;
      d.panel_mem_option_reg = PANEL_MEM_OPTION_RST;
      d.cas_hi = '1;
      d.cas_lo = '1;
      d.we = '1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign col_strobe_hi_n = q.cas_hi;
  assign col_strobe_lo_n = q.cas_lo;
  assign write_strobe_n = q.we;
  assign main_edo = q.dram_type_reg[TYPE_LO +: 2] == TYPE_EDO; // RULE_07
  assign buf_edo = q.panel_mem_option_reg[PMO_BUF_EDO]; // RULE_08
  assign buf_active = buf_en;
  assign wide_path = wide;

endmodule // display_dram_strobe_config
`default_nettype wire

// ### hw/dram_strobe_pkg.sv
// Constants and types for the display DRAM strobe mapping block
package dram_strobe_pkg;
  // Register byte addresses on the bus
  localparam logic [3:0] ADDR_DRAM_TYPE = 4'h0;
  localparam logic [3:0] ADDR_DRAM_CONFIG = 4'h4;
  localparam logic [3:0] ADDR_PANEL_MEM_OPTION = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  // Field positions
  localparam int TYPE_LO = 0;
  localparam int CFG_DUAL_WE = 4;
  localparam int CFG_SIZE_LO = 0;
  localparam int CFG_WIDE = 3;
  localparam int PMO_BUF_EN0 = 0;
  localparam int PMO_BUF_EDO = 2;
  localparam int PMO_BUF_DUAL_WE = 6;
  localparam int PMO_BUF_EN7 = 7;
  // Reset values
  localparam logic [7:0] DRAM_TYPE_RST = 8'h00;
  localparam logic [7:0] DRAM_CONFIG_RST = 8'h08;
  localparam logic [7:0] PANEL_MEM_OPTION_RST = 8'h00;
  // Memory type encodings
  localparam logic [1:0] TYPE_FPM = 2'h0;
  localparam logic [1:0] TYPE_EDO = 2'h1;
  // Total size encodings: 1, 2, 4 megabytes
  localparam logic [1:0] SIZE_1MB = 2'h0;
  localparam logic [1:0] SIZE_2MB = 2'h1;
  localparam logic [1:0] SIZE_4MB = 2'h2;
  localparam int NUM_GRP = 4;
  localparam int GRP_C = 2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK = 2'b01
  } bus_state_t;
endpackage

// ### verif/strobe_checker_assertions.sv
// Port assertions for the display DRAM strobe block
`timescale 1ns/1ps
`default_nettype none
module strobe_checker
  import dram_strobe_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NUM_GRP-1:0] main_cas_n,
  input wire logic main_we_n,
  input wire logic [NUM_GRP-1:0] col_strobe_hi_n,
  input wire logic [NUM_GRP-1:0] col_strobe_lo_n,
  input wire logic [NUM_GRP-1:0] write_strobe_n,
  input wire logic buf_active,
  input wire logic wide_path
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  a_ack_pulse: assert property (s_req |=> s_ack)
    else $error("ack pulse");
  a_read_upper: assert property (wb_ack_o && !wb_we_i |-> !(|wb_dat_o[31:8]))
    else $error("upper read bits");
  a_buf_narrow: assert property (buf_active |-> !wide_path)
    else $error("buffer with wide path");
  a_grp_d_idle: assert property (!$past(wide_path) |->
    col_strobe_hi_n[3] && col_strobe_lo_n[3] && write_strobe_n[3])
    else $error("group D active");
  a_grp_c_idle: assert property (!$past(wide_path) &&
    !$past(buf_active) |-> col_strobe_hi_n[2] && write_strobe_n[2])
    else $error("group C active");
  a_read_no_we: assert property ($past(main_we_n) |->
    write_strobe_n[1:0] == 2'h3) else $error("write strobe on read");
  a_cas_idle: assert property ($past(main_cas_n[0]) |->
    col_strobe_hi_n[0] && col_strobe_lo_n[0]) else $error("stray CAS");
  a_reset_wide: assert property ($fell(rst) |-> wide_path && !buf_active)
    else $error("reset configuration");
endmodule // strobe_checker
bind display_dram_strobe_config strobe_checker i_strobe_checker (.*);
`default_nettype wire

// ### verif/dram_byte_model.sv
// Far-side DRAM model decoding byte writes from the strobe pins
`timescale 1ns/1ps
`default_nettype none
module dram_byte_model
  import dram_strobe_pkg::*;
(
  input wire logic [NUM_GRP-1:0] col_strobe_hi_n,
  input wire logic [NUM_GRP-1:0] col_strobe_lo_n,
  input wire logic [NUM_GRP-1:0] write_strobe_n,
  input wire logic [NUM_GRP-1:0] dual_we,
  output logic [2*NUM_GRP-1:0] byte_wr
);
  always_comb begin
    for (int g = 0; g < NUM_GRP; g++) begin
      byte_wr[2*g] = !col_strobe_lo_n[g] && (dual_we[g] ?
        !col_strobe_hi_n[g] : !write_strobe_n[g]);
      byte_wr[2*g+1] = !col_strobe_hi_n[g] && !write_strobe_n[g];
    end
  end
endmodule // dram_byte_model
`default_nettype wire

// ### verif/tb_top.sv
// Randomised self-checking bench for the display DRAM strobe block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dram_strobe_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, main_we_n = 1'b1, buf_cas_n = 1'b1, buf_we_n = 1'b1;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1, main_cas_n = 4'hF, dual_we;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd;
  logic [7:0] main_byte_en = 8'h00, byte_wr, cfg, opt, ew;
  logic [1:0] buf_byte_en = 2'h0;
  logic [3:0] col_strobe_hi_n, col_strobe_lo_n, write_strobe_n;
  logic wb_ack_o, main_edo, buf_edo, buf_active, wide_path, wide, bufa;
  logic [11:0] ep, gp;
  logic [7:0] corner [4] = '{8'h81, 8'h80, 8'h01, 8'hC5};
  int n_fail = 0, comparisons = 0;
  display_dram_strobe_config i_display_dram_strobe_config (.*);
  dram_byte_model i_dram_byte_model (.*);
  always #5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("%0d mismatches in %0d checks", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1 && n++ < 20);
    if (n > 20) begin
      n_fail++;
      complete_run();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  function automatic logic [2:0] pin(logic c, w, logic [1:0] b, logic d);
    if (d) return {c, !(!c && !w && b[0]), !(!c && !w && b[1])};
    return {!(!c && b[1]), !(!c && b[0]), w};
  endfunction
  task automatic set_cfg(input logic [7:0] t, c, o);
    cfg = c;
    opt = o;
    wb(1'b1, ADDR_DRAM_TYPE, t);
    wb(1'b1, ADDR_DRAM_CONFIG, c);
    wb(1'b1, ADDR_PANEL_MEM_OPTION, o);
    bufa = o[PMO_BUF_EN7] && o[PMO_BUF_EN0];
    wide = c[CFG_WIDE] && !bufa;
    dual_we = {c[4], wide ? c[4] : o[6], c[4], c[4]};
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk("status", {bufa, wide, t[1:0] == 2'h1, c[1:0] == 2'h3 ? 2'h2 : c[1:0]},
      rd);
    chk("decode", {bufa, wide, t[1:0] == 2'h1, o[2]}, {buf_active, wide_path,
      main_edo, buf_edo});
  endtask
  task automatic strobe_cycle;
    @(posedge clk);
    main_cas_n <= 4'($urandom);
    main_we_n <= 1'($urandom);
    main_byte_en <= 8'($urandom);
    buf_cas_n <= 1'($urandom);
    buf_we_n <= 1'($urandom);
    buf_byte_en <= 2'($urandom);
    @(posedge clk);
    @(negedge clk);
    ep = 12'hFFF;
    ew = 8'h00;
    for (int g = 0; g < 4; g++) begin
      gp[3*g+:3] = {col_strobe_hi_n[g], col_strobe_lo_n[g], write_strobe_n[g]};
      if (g < 2 || wide) begin
        ep[3*g+:3] = pin(main_cas_n[g], main_we_n, main_byte_en[2*g+:2], cfg[4]);
        ew[2*g+:2] = {2{!main_cas_n[g] && !main_we_n}} & main_byte_en[2*g+:2];
      end else if (g == 2 && bufa) begin
        ep[6+:3] = pin(buf_cas_n, buf_we_n, buf_byte_en, opt[6]);
        ew[4+:2] = {2{!buf_cas_n && !buf_we_n}} & buf_byte_en;
      end
    end
    chk("pins", ep, gp);
    chk("bytes", ew, byte_wr);
  endtask
  task automatic reset_check;
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, ADDR_DRAM_CONFIG, 8'h00);
    chk("config reset", DRAM_CONFIG_RST, rd);
    wb(1'b0, 4'h2, 8'h00);
    chk("unmapped", 32'h00000000, rd);
  endtask
  initial begin
    void'($urandom(32'h7FDA7676));
    reset_check();
    for (int i = 0; i < 40; i++) begin
      set_cfg(8'($urandom), 8'($urandom), i < 4 ? corner[i] : 8'($urandom));
      repeat (6) strobe_cycle();
    end
    reset_check();
    complete_run();
  end
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
